// ### rtl/nv_handoff_pkg.sv
package nv_handoff_pkg;
  // =====================================
  // addressing and bank layout
  localparam int ROW_BITS = 16;
  localparam int COL_BITS = 10;
  localparam int BG_BITS = 2;
  localparam int BA_BITS = 2;
  localparam int GROUPS = 4;
  localparam int BANKS_PER_GROUP = 4;
  localparam int BANKS = GROUPS * BANKS_PER_GROUP;
  // =====================================
  // burst and latency
  localparam logic [3:0] BURST_CHOP_FOUR_LEN = 4'h4;
  localparam logic [3:0] BURST_LENGTH_EIGHT_LEN = 4'h8;
  localparam logic [4:0] CAS_LATENCY_FAST = 5'h11;
  localparam logic [4:0] CAS_LATENCY_SLOW = 5'h0f;
  localparam real FAST_CLK_PERIOD_NS = 0.83;
  // =====================================
  // module controller timing, in ref clock cycles
  localparam logic [15:0] SAVE_CYCLES = 16'h0040;
  localparam logic [15:0] RESTORE_CYCLES = 16'h0040;
  localparam logic [15:0] SHUTDOWN_CYCLES = 16'h0004;
  // =====================================
  // module controller states, gray along save path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SAVE = 3'h1,
    ST_DOWN = 3'h3,
    ST_OFF = 3'h2,
    ST_RESTORE = 3'h6
  } nv_state_e;
  // host states
  typedef enum logic [2:0] {
    H_RUN = 3'h0,
    H_DRAIN = 3'h1,
    H_SELF_REFRESH = 3'h3,
    H_HANDED = 3'h2,
    H_EXIT = 3'h6
  } host_state_e;
endpackage

// ### rtl/nv_handoff_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nv_handoff_if;
  logic sdram_clk_enable_zero;
  logic sdram_reset_n;
  logic rank_select_n;
  logic [nv_handoff_pkg::ROW_BITS-1:0] addr;
  logic [nv_handoff_pkg::BG_BITS-1:0] bank_group_select;
  logic [nv_handoff_pkg::BA_BITS-1:0] bank_select;
  logic per_command_burst_select;
  logic save_req_n;
  logic mgmt_save_cmd;
  logic mgmt_restore_cmd;
  logic module_owns;
  logic restore_done;
  modport host (
    output sdram_clk_enable_zero, sdram_reset_n, rank_select_n, addr,
    output bank_group_select, bank_select, per_command_burst_select,
    output save_req_n, mgmt_save_cmd, mgmt_restore_cmd,
    input module_owns, restore_done
  );
  modport module_end (
    input sdram_clk_enable_zero, sdram_reset_n, rank_select_n, addr,
    input bank_group_select, bank_select, per_command_burst_select,
    input save_req_n, mgmt_save_cmd, mgmt_restore_cmd,
    output module_owns, restore_done
  );
endinterface
`default_nettype wire

// ### rtl/nv_module_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module nv_module_ctrl #(
  parameter logic [15:0] SAVE_LEN = nv_handoff_pkg::SAVE_CYCLES,
  parameter logic [15:0] RESTORE_LEN = nv_handoff_pkg::RESTORE_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  nv_handoff_if.module_end link,
  input wire logic system_power_good_in,
  input wire logic cke_trigger_enable_in,
  output logic flash_write_out,
  output logic [nv_handoff_pkg::BG_BITS+nv_handoff_pkg::BA_BITS-1:0] flash_bank_out,
  output logic saved_valid_out,
  output logic shutdown_out,
  output logic [3:0] burst_len_out,
  output logic [nv_handoff_pkg::BANKS-1:0] bank_open_out
);
  // =====================================
  // trigger detection
  nv_handoff_pkg::nv_state_e state;
  logic [15:0] count;
  logic cke_prev;
  logic cke_fall;
  logic trigger;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cke_prev <= 1'b1;
    end else begin
      cke_prev <= link.sdram_clk_enable_zero;
    end
  end

  assign cke_fall = cke_prev & ~link.sdram_clk_enable_zero;
  assign trigger = ~link.save_req_n | (cke_fall & cke_trigger_enable_in) | link.mgmt_save_cmd;

  // =====================================
  // save / restore sequencer
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= nv_handoff_pkg::ST_IDLE;
      count <= 16'h0000;
    end else begin
      case (state)
        nv_handoff_pkg::ST_IDLE: begin
          count <= 16'h0000;
          // save only from self refresh
          // explicit restore wins: its self-refresh entry also drops clock enable
          if (link.mgmt_restore_cmd && !link.sdram_clk_enable_zero) begin
            state <= nv_handoff_pkg::ST_RESTORE;
          end else if (trigger && !link.sdram_clk_enable_zero) begin
            state <= nv_handoff_pkg::ST_SAVE;
          end
        end
        nv_handoff_pkg::ST_SAVE: begin
          count <= count + 16'h0001;
          // copy every bank, then shut down only if system power is not good, else back to idle
          if (count == SAVE_LEN - 16'h0001) begin
            count <= 16'h0000;
            state <= system_power_good_in ? nv_handoff_pkg::ST_IDLE
                                          : nv_handoff_pkg::ST_DOWN;
          end
        end
        nv_handoff_pkg::ST_DOWN: begin
          count <= count + 16'h0001;
          if (count == nv_handoff_pkg::SHUTDOWN_CYCLES - 16'h0001) begin
            state <= nv_handoff_pkg::ST_OFF;
          end
        end
        nv_handoff_pkg::ST_OFF: begin
          count <= 16'h0000;
        end
        nv_handoff_pkg::ST_RESTORE: begin
          count <= count + 16'h0001;
          if (count == RESTORE_LEN - 16'h0001) begin
            count <= 16'h0000;
            state <= nv_handoff_pkg::ST_IDLE;
          end
        end
        default: state <= nv_handoff_pkg::ST_IDLE;
      endcase
    end
  end

  // =====================================
  // outputs
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flash_write_out <= 1'b0;
      flash_bank_out <= '0;
      saved_valid_out <= 1'b0;
      shutdown_out <= 1'b0;
      link.restore_done <= 1'b0;
    end else begin
      flash_write_out <= (state == nv_handoff_pkg::ST_SAVE);
      flash_bank_out <= count[3:0];
      shutdown_out <= (state == nv_handoff_pkg::ST_OFF);
      link.restore_done <= (state == nv_handoff_pkg::ST_RESTORE) &&
                           (count == RESTORE_LEN - 16'h0001);
      if (state == nv_handoff_pkg::ST_SAVE && count == SAVE_LEN - 16'h0001) begin
        saved_valid_out <= 1'b1;
      end
    end
  end

  assign link.module_owns = (state == nv_handoff_pkg::ST_SAVE) ||
                            (state == nv_handoff_pkg::ST_RESTORE) ||
                            (state == nv_handoff_pkg::ST_DOWN);

  // =====================================
  // burst mode and bank tracking (SDRAM side view)
  logic mode_chop;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_chop <= 1'b0;
      burst_len_out <= nv_handoff_pkg::BURST_LENGTH_EIGHT_LEN;
    end else if (link.sdram_clk_enable_zero && !link.rank_select_n) begin
      burst_len_out <= (link.per_command_burst_select | mode_chop)
                       ? nv_handoff_pkg::BURST_CHOP_FOUR_LEN
                       : nv_handoff_pkg::BURST_LENGTH_EIGHT_LEN;
      // mode write modelled as a command with the top address bit set, a12 as chop bit
      if (link.addr[nv_handoff_pkg::ROW_BITS-1]) begin
        mode_chop <= link.addr[12];
      end
    end
  end

  // decode group and bank into one slot
  genvar g;
  generate
    for (g = 0; g < nv_handoff_pkg::BANKS; g++) begin : gen_bank
      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          bank_open_out[g] <= 1'b0;
        end else if (!link.sdram_reset_n) begin
          bank_open_out[g] <= 1'b0;
        end else if (link.sdram_clk_enable_zero && !link.rank_select_n &&
                     {link.bank_group_select, link.bank_select} == 4'(g)) begin
          bank_open_out[g] <= 1'b1;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### rtl/nv_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module nv_host_ctrl #(
  parameter logic [4:0] CAS_LATENCY = nv_handoff_pkg::CAS_LATENCY_FAST
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  nv_handoff_if.host link,
  input wire logic power_fail_warn_in,
  input wire logic restore_req_in,
  input wire logic cmd_valid_in,
  input wire logic [nv_handoff_pkg::ROW_BITS-1:0] cmd_addr_in,
  input wire logic [3:0] cmd_bank_in,
  input wire logic cmd_chop_in,
  output logic cmd_ready_out,
  output logic [4:0] cas_latency_cycles_out,
  output logic handed_off_out
);
  nv_handoff_pkg::host_state_e state;
  logic restored;

  // =====================================
  // handoff sequencer
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= nv_handoff_pkg::H_RUN;
      restored <= 1'b0;
    end else begin
      case (state)
        nv_handoff_pkg::H_RUN: begin
          if (power_fail_warn_in || restore_req_in) begin
            state <= nv_handoff_pkg::H_DRAIN;
          end
        end
        nv_handoff_pkg::H_DRAIN: state <= nv_handoff_pkg::H_SELF_REFRESH;
        nv_handoff_pkg::H_SELF_REFRESH: state <= nv_handoff_pkg::H_HANDED;
        nv_handoff_pkg::H_HANDED: begin
          if (link.restore_done) begin
            restored <= 1'b1;
          end
          if (!link.module_owns && !power_fail_warn_in && !restore_req_in) begin
            state <= nv_handoff_pkg::H_EXIT;
          end
        end
        nv_handoff_pkg::H_EXIT: state <= nv_handoff_pkg::H_RUN;
        default: state <= nv_handoff_pkg::H_RUN;
      endcase
    end
  end

  // =====================================
  // pins
  logic active;
  assign active = (state == nv_handoff_pkg::H_RUN);
  assign cmd_ready_out = active;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      link.sdram_clk_enable_zero <= 1'b1;
      link.sdram_reset_n <= 1'b0;
      link.rank_select_n <= 1'b1;
      link.addr <= '0;
      link.bank_group_select <= '0;
      link.bank_select <= '0;
      link.per_command_burst_select <= 1'b0;
      link.save_req_n <= 1'b1;
      link.mgmt_save_cmd <= 1'b0;
      link.mgmt_restore_cmd <= 1'b0;
      handed_off_out <= 1'b0;
      cas_latency_cycles_out <= CAS_LATENCY;
    end else begin
      link.sdram_reset_n <= 1'b1;
      cas_latency_cycles_out <= CAS_LATENCY;
      link.sdram_clk_enable_zero <= (state == nv_handoff_pkg::H_RUN) ||
                                    (state == nv_handoff_pkg::H_DRAIN) ||
                                    (state == nv_handoff_pkg::H_EXIT);
      link.rank_select_n <= ~(active & cmd_valid_in);
      if (active && cmd_valid_in) begin
        // row, group and bank to pins
        link.addr <= cmd_addr_in;
        link.bank_group_select <= cmd_bank_in[3:2];
        link.bank_select <= cmd_bank_in[1:0];
        link.per_command_burst_select <= cmd_chop_in;
      end
      link.save_req_n <= ~((state == nv_handoff_pkg::H_HANDED) && power_fail_warn_in);
      link.mgmt_save_cmd <= 1'b0;
      link.mgmt_restore_cmd <= (state == nv_handoff_pkg::H_SELF_REFRESH) &&
                               restore_req_in && !power_fail_warn_in && !restored;
      handed_off_out <= (state == nv_handoff_pkg::H_HANDED);
    end
  end
endmodule
`default_nettype wire

// ### verif/nv_handoff_chk.sv
`timescale 1ns/1ps
`default_nettype none
module nv_handoff_chk #(
  parameter logic [15:0] RESTORE_LEN = nv_handoff_pkg::RESTORE_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic sdram_clk_enable_zero,
  input wire logic sdram_reset_n,
  input wire logic rank_select_n,
  input wire logic save_req_n,
  input wire logic mgmt_restore_cmd,
  input wire logic module_owns,
  input wire logic restore_done
);
  // slack both ways for the handshake registers on each side
  localparam int RD_MIN = RESTORE_LEN - 2;
  localparam int RD_MAX = RESTORE_LEN + 4;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // =====================================
  // sequences
  sequence restore_s;
    ##[RD_MIN:RD_MAX] restore_done;
  endsequence
  sequence exit_s;
    ##[1:4] sdram_clk_enable_zero;
  endsequence
  // =====================================
  // properties
  owns_after_cke_a: assert property ($rose(module_owns) |-> !$past(sdram_clk_enable_zero))
    else $error("module took the memory with clock enable high");
  owns_cke_low_a: assert property (module_owns |-> !sdram_clk_enable_zero)
    else $error("clock enable high while module owns the memory");
  owns_quiet_a: assert property (module_owns |-> rank_select_n && sdram_reset_n)
    else $error("host command or reset while module owns the memory");
  save_answer_a: assert property ($fell(save_req_n) |-> ##[0:1] module_owns)
    else $error("save request not answered");
  save_in_sr_a: assert property ($fell(save_req_n) |-> !$past(sdram_clk_enable_zero))
    else $error("save requested before self refresh");
  cke_hold_a: assert property ($fell(sdram_clk_enable_zero) |-> !sdram_clk_enable_zero [*3])
    else $error("self refresh left too early");
  restore_time_a: assert property ($rose(mgmt_restore_cmd) |-> restore_s)
    else $error("restore done not in time");
  restore_exit_a: assert property ($rose(restore_done) |-> exit_s)
    else $error("self refresh not left after restore");
  no_reset_a: assert property ($rose(restore_done) |=> sdram_reset_n [*8])
    else $error("memory reset after restore");
endmodule
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module testbench;
  typedef struct {logic [15:0] addr; logic [3:0] bank; logic chop; logic [3:0] burst;} row_s;
  logic clk = 1'b0, rst_in = 1'b1, pgood = 1'b1, warn = 1'b0, rreq = 1'b0, cv = 1'b0, chop = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [3:0] bank = 4'h0, burst_len;
  logic [15:0] open_mask, exp_open;
  logic [3:0] fbank;
  logic fw, sv, sd, ready, handed;
  logic [4:0] cas;
  int bad_count = 0, checks_done = 0;
  // last two rows: mode write fixes chop four, then a plain command obeys it
  row_s rows [6] = '{'{16'h0000, 4'h0, 1'b1, 4'h4}, '{16'h7fff, 4'hf, 1'b0, 4'h8},
    '{16'h1234, 4'h5, 1'b1, 4'h4}, '{16'h4321, 4'ha, 1'b0, 4'h8},
    '{16'h9000, 4'h3, 1'b0, 4'h8}, '{16'h0abc, 4'hc, 1'b0, 4'h4}};
  nv_handoff_if link_if ();
  nv_host_ctrl nv_host_ctrl_inst (.ref_clk_in(clk), .rst_in(rst_in), .link(link_if),
    .power_fail_warn_in(warn), .restore_req_in(rreq), .cmd_valid_in(cv), .cmd_addr_in(addr),
    .cmd_bank_in(bank), .cmd_chop_in(chop), .cmd_ready_out(ready),
    .cas_latency_cycles_out(cas), .handed_off_out(handed));
  nv_module_ctrl #(.SAVE_LEN(16'h0008), .RESTORE_LEN(16'h0008)) nv_module_ctrl_inst (
    .ref_clk_in(clk), .rst_in(rst_in), .link(link_if), .system_power_good_in(pgood),
    .cke_trigger_enable_in(1'b1), .flash_write_out(fw), .flash_bank_out(fbank),
    .saved_valid_out(sv), .shutdown_out(sd), .burst_len_out(burst_len),
    .bank_open_out(open_mask));
  nv_handoff_chk #(.RESTORE_LEN(16'h0008)) nv_handoff_chk_inst (.ref_clk_in(clk),
    .rst_in(rst_in), .sdram_clk_enable_zero(link_if.sdram_clk_enable_zero),
    .sdram_reset_n(link_if.sdram_reset_n), .rank_select_n(link_if.rank_select_n),
    .save_req_n(link_if.save_req_n), .mgmt_restore_cmd(link_if.mgmt_restore_cmd),
    .module_owns(link_if.module_owns), .restore_done(link_if.restore_done));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic step();
    @(posedge clk);
    #5;
  endtask
  task automatic end_sim();
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bounded wait; a miss shows up in the compare after it
  `define WAITF(c) for (int i = 0; i < 300 && !(c); i++) step();
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (12) step();
    rst_in = 1'b0;
    step();
    `CHK(link_if.sdram_reset_n, 1'b1) // reset released
    `CHK(link_if.sdram_clk_enable_zero, 1'b1) // clock on
    `CHK(cas, 5'h11) // fast latency
    `CHK(burst_len, 4'h8) // default length
    exp_open = 16'h0000;
    foreach (rows[k]) begin
      `WAITF(ready === 1'b1)
      {cv, addr, bank, chop} = {1'b1, rows[k].addr, rows[k].bank, rows[k].chop};
      step();
      cv = 1'b0;
      `CHK({link_if.addr, link_if.bank_group_select, link_if.bank_select}, {addr, bank})
      `CHK(link_if.per_command_burst_select, chop) // per command
      repeat (3) step();
      exp_open[bank] = 1'b1;
      `CHK(burst_len, rows[k].burst) // burst size
      `CHK(open_mask, exp_open) // sixteen slots
    end
    // power fail: host hands off, then supply drops mid save
    warn = 1'b1;
    `WAITF(handed === 1'b1)
    `CHK(link_if.sdram_clk_enable_zero, 1'b0) // self refresh first
    `CHK(ready, 1'b0) // commands refused
    `WAITF(fw === 1'b1)
    `CHK(link_if.module_owns, 1'b1) // save started
    `CHK(fbank, 4'h0) // copy starts at slot zero
    pgood = 1'b0;
    `WAITF(sd === 1'b1)
    `CHK({sv, sd}, 2'b11) // saved then off
    // power back: forced restore, no memory reset after it
    {rst_in, warn, pgood} = 3'b101;
    repeat (2) step();
    rst_in = 1'b0;
    rreq = 1'b1;
    `WAITF(link_if.restore_done === 1'b1)
    `CHK(link_if.restore_done, 1'b1) // restore finished
    rreq = 1'b0;
    `WAITF(ready === 1'b1)
    `CHK(link_if.sdram_clk_enable_zero, 1'b1) // self refresh left
    `CHK(link_if.sdram_reset_n, 1'b1) // no reset after restore
    end_sim();
  end
endmodule
`default_nettype wire
